// *** src/charge_detect_pkg.sv ***
// Purpose: constants for the charger detection register bank
// Assumes: 16-bit registers, word index = byte offset / 2 low bits
// Notes: offsets are the low byte address bits of each register
package charge_detect_pkg;
	localparam int ADDR_W = 20;
	localparam int DATA_W = 16;
	localparam logic [19:0] PORT0_CTRL_ADDR = 20'hF04B0;
	localparam logic [19:0] PORT1_CTRL_ADDR = 20'hF04B4;
	localparam logic [19:0] PORT0_OPT_ADDR = 20'hF04B8;
	localparam logic [19:0] PORT1_OPT_ADDR = 20'hF04BC;
	localparam logic [15:0] RESET_VALUE = 16'h0000;
	// port 0 control fields
	localparam int C_DP_FLAG = 9;
	localparam int C_DM_FLAG = 8;
	localparam int C_ENABLE = 7;
	localparam int C_RESISTOR = 6;
	localparam int C_DM_SRC = 5;
	localparam int C_DP_SINK = 4;
	localparam int C_DP_SRC = 3;
	localparam int C_DM_SINK = 2;
	localparam int C_DP_ISRC = 1;
	localparam int C_DM_PD = 0;
	// writable masks
	localparam logic [15:0] CTRL0_WMASK = 16'h00FF;
	localparam logic [15:0] CTRL1_WMASK = 16'h00F0;
	// option fields
	localparam int O_DM_FLAG = 9;
	localparam int O_DP_FLAG = 8;
	localparam int O_DET_EN = 6;
	localparam int O_OUT_EN = 5;
	localparam int O_SEL_LSB = 0;
	localparam int O_SEL_W = 4;
	localparam logic [15:0] OPT_WMASK = 16'h006F;
	// host output codes
	localparam logic [3:0] SEL_BOTH_200 = 4'h8;
	localparam logic [3:0] SEL_DP_268 = 4'h9;
	localparam logic [3:0] SEL_DM_268 = 4'hA;
	localparam logic [3:0] SEL_BOTH_330 = 4'hC;
	localparam int SYNC_STAGES = 3;
endpackage

// *** src/usb_charger_detect_ctrl.sv ***
// Purpose: charger detection control and status registers, two ports
// Assumes: comparator results arrive asynchronously from the analog side
// Notes: analog controls are registered outputs; sources, sinks and current source are gated by the port enable
// Notes: flags read 0 unless their sink or detector enables are set
// Notes: port1 option output is held off for an illegal host code
// Function
// - port0 dplus flag read-only, detects source
// - port0 dminus flag read-only, valid with sink
// - port0 enable gates sources, sinks, current
// - resistor bit connects charging port resistor
// - source enable drives 0.6 V source
// - sink enable enables sink and comparator
// - current source enable drives 10 uA
// - pull-down bit acts on dminus only
// - port1 register holds only five fields
// - unassigned bits read zero, writes ignored
// - option flags read-only, valid with detector
// - host use flags report range exit
// - function use flags report above threshold
// - separate detector and output enables
// - output enabled allows four host codes; port0 output ignores the code
// - port0 function use uses all sixteen thresholds
// - port1 option detection host use only
// - port0 control at its address, resets zero
`timescale 1ns/10ps
`default_nettype none
module usb_charger_detect_ctrl #(
	parameter int SYNC_STAGES = charge_detect_pkg::SYNC_STAGES
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [19:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	// raw comparator results: p0 dp, p0 dm, p1 dp, opt p0 dp/dm, opt p1 dp/dm
	input wire logic p0_dplus_cmp_i,
	input wire logic p0_dminus_cmp_i,
	input wire logic p1_dplus_cmp_i,
	input wire logic p0_opt_dplus_cmp_i,
	input wire logic p0_opt_dminus_cmp_i,
	input wire logic p1_opt_dplus_cmp_i,
	input wire logic p1_opt_dminus_cmp_i,
	// port 0 analog controls
	output logic p0_dplus_volt_source_o,
	output logic p0_dminus_volt_source_o,
	output logic p0_dplus_sink_o,
	output logic p0_dminus_sink_o,
	output logic p0_dplus_current_source_o,
	output logic p0_dminus_pulldown_o,
	output logic p0_charging_port_resistor_o,
	// port 1 analog controls
	output logic p1_dminus_volt_source_o,
	output logic p1_dplus_sink_o,
	output logic p1_charging_port_resistor_o,
	// option controls
	output logic p0_opt_detector_o,
	output logic p0_opt_output_o,
	output logic [3:0] p0_opt_voltage_select_o,
	output logic p1_opt_detector_o,
	output logic p1_opt_output_o,
	output logic [3:0] p1_opt_voltage_select_o
);
	localparam int NCMP = 7;
	// comparator slots in the synchroniser vector
	localparam int K_P0_DP = 0;
	localparam int K_P0_DM = 1;
	localparam int K_P1_DP = 2;
	localparam int K_P0_ODP = 3;
	localparam int K_P0_ODM = 4;
	localparam int K_P1_ODP = 5;
	localparam int K_P1_ODM = 6;
	localparam int SEL_LSB = charge_detect_pkg::O_SEL_LSB;
	localparam int SEL_W = charge_detect_pkg::O_SEL_W;
	// field positions, shortened from the package
	localparam int F_DP_FLAG = charge_detect_pkg::C_DP_FLAG;
	localparam int F_DM_FLAG = charge_detect_pkg::C_DM_FLAG;
	localparam int F_ENABLE = charge_detect_pkg::C_ENABLE;
	localparam int F_RESISTOR = charge_detect_pkg::C_RESISTOR;
	localparam int F_DM_SRC = charge_detect_pkg::C_DM_SRC;
	localparam int F_DP_SINK = charge_detect_pkg::C_DP_SINK;
	localparam int F_DP_SRC = charge_detect_pkg::C_DP_SRC;
	localparam int F_DM_SINK = charge_detect_pkg::C_DM_SINK;
	localparam int F_DP_ISRC = charge_detect_pkg::C_DP_ISRC;
	localparam int F_DM_PD = charge_detect_pkg::C_DM_PD;
	localparam int F_ODM_FLAG = charge_detect_pkg::O_DM_FLAG;
	localparam int F_ODP_FLAG = charge_detect_pkg::O_DP_FLAG;
	localparam int F_DET_EN = charge_detect_pkg::O_DET_EN;
	localparam int F_OUT_EN = charge_detect_pkg::O_OUT_EN;

	typedef struct packed {
		// software visible registers
		logic [15:0] ctrl0_reg;
		logic [15:0] ctrl1_reg;
		logic [15:0] opt0_reg;
		logic [15:0] opt1_reg;
		// comparator synchroniser and filtered levels
		logic [NCMP-1:0] s1_reg;
		logic [NCMP-1:0] s2_reg;
		logic [NCMP-1:0] s3_reg;
		logic [NCMP-1:0] cmp_reg;
		// read data, valid the cycle after a read strobe
		logic [15:0] rdata_reg;
		// port 0 analog controls
		logic p0_dp_src_reg;
		logic p0_dm_src_reg;
		logic p0_dp_sink_reg;
		logic p0_dm_sink_reg;
		logic p0_dp_isrc_reg;
		logic p0_dm_pd_reg;
		logic p0_res_reg;
		// port 1 analog controls
		logic p1_dm_src_reg;
		logic p1_dp_sink_reg;
		logic p1_res_reg;
		// option controls
		logic p0_odet_reg;
		logic p0_oout_reg;
		logic [SEL_W-1:0] p0_osel_reg;
		logic p1_odet_reg;
		logic p1_oout_reg;
		logic [SEL_W-1:0] p1_osel_reg;
	} state_t;

	state_t st_reg;
	state_t st_next;
	logic [NCMP-1:0] raw;
	logic [NCMP-1:0] agree;
	logic [15:0] c0;
	logic [15:0] c1;
	logic [15:0] o0;
	logic [15:0] o1;
	logic p0_on;
	logic p1_on;
	logic o0_det;
	logic o1_det;
	logic o1_out;
	logic p0_dp_f;
	logic p0_dm_f;
	logic p1_dp_f;
	logic p0_odp_f;
	logic p0_odm_f;
	logic p1_odp_f;
	logic p1_odm_f;
	logic [15:0] rd_val;
	logic [SEL_W-1:0] wr_sel;
	logic [SEL_W-1:0] p1_sel;
	logic p1_host_code;
	logic hit_c0;
	logic hit_c1;
	logic hit_o0;
	logic hit_o1;

	// the synchroniser and filter are written for exactly three stages
	if (SYNC_STAGES != 3) begin : g_chk
		$error("SYNC_STAGES must be 3");
	end

	// raw comparator levels, one slot each
	assign raw[K_P0_DP] = p0_dplus_cmp_i;
	assign raw[K_P0_DM] = p0_dminus_cmp_i;
	assign raw[K_P1_DP] = p1_dplus_cmp_i;
	assign raw[K_P0_ODP] = p0_opt_dplus_cmp_i;
	assign raw[K_P0_ODM] = p0_opt_dminus_cmp_i;
	assign raw[K_P1_ODP] = p1_opt_dplus_cmp_i;
	assign raw[K_P1_ODM] = p1_opt_dminus_cmp_i;

	// address decode, shared by reads and writes
	always_comb begin
		hit_c0 = 1'b0;
		hit_c1 = 1'b0;
		hit_o0 = 1'b0;
		hit_o1 = 1'b0;
		if (addr_i == charge_detect_pkg::PORT0_CTRL_ADDR) begin
			hit_c0 = 1'b1;
		end else if (addr_i == charge_detect_pkg::PORT1_CTRL_ADDR) begin
			hit_c1 = 1'b1;
		end else if (addr_i == charge_detect_pkg::PORT0_OPT_ADDR) begin
			hit_o0 = 1'b1;
		end else if (addr_i == charge_detect_pkg::PORT1_OPT_ADDR) begin
			hit_o1 = 1'b1;
		end
	end

	always_comb begin
		st_next = st_reg;
		c0 = st_reg.ctrl0_reg;
		c1 = st_reg.ctrl1_reg;
		o0 = st_reg.opt0_reg;
		o1 = st_reg.opt1_reg;

		st_next.s1_reg = raw;
		st_next.s2_reg = st_reg.s1_reg;
		st_next.s3_reg = st_reg.s2_reg;
		// a level counts once the last two stages agree
		agree = ~(st_reg.s2_reg ^ st_reg.s3_reg);
		for (int i = 0; i < NCMP; i++) begin
			if (agree[i]) begin
				st_next.cmp_reg[i] = st_reg.s3_reg[i];
			end
		end

		p0_on = c0[F_ENABLE];
		p1_on = c1[F_ENABLE];
		o0_det = o0[F_DET_EN];
		o1_det = o1[F_DET_EN];
		o1_out = o1[F_OUT_EN];

		p0_dp_f = st_reg.cmp_reg[K_P0_DP] & p0_on
			& c0[F_DP_SINK];
		p0_dm_f = st_reg.cmp_reg[K_P0_DM] & p0_on
			& c0[F_DM_SINK];
		// port1 dplus flag, valid with sink
		p1_dp_f = st_reg.cmp_reg[K_P1_DP] & p1_on
			& c1[F_DP_SINK];

		p0_odp_f = st_reg.cmp_reg[K_P0_ODP] & o0_det;
		p0_odm_f = st_reg.cmp_reg[K_P0_ODM] & o0_det;
		// port1 flags only in host use
		p1_odp_f = st_reg.cmp_reg[K_P1_ODP] & o1_det & o1_out;
		p1_odm_f = st_reg.cmp_reg[K_P1_ODM] & o1_det & o1_out;

		rd_val = charge_detect_pkg::RESET_VALUE;
		if (hit_c0) begin
			rd_val[F_DP_FLAG] = p0_dp_f;
			rd_val[F_DM_FLAG] = p0_dm_f;
			rd_val[F_ENABLE] = c0[F_ENABLE];
			rd_val[F_RESISTOR] = c0[F_RESISTOR];
			rd_val[F_DM_SRC] = c0[F_DM_SRC];
			rd_val[F_DP_SINK] = c0[F_DP_SINK];
			rd_val[F_DP_SRC] = c0[F_DP_SRC];
			rd_val[F_DM_SINK] = c0[F_DM_SINK];
			rd_val[F_DP_ISRC] = c0[F_DP_ISRC];
			rd_val[F_DM_PD] = c0[F_DM_PD];
		end else if (hit_c1) begin
			rd_val[F_DP_FLAG] = p1_dp_f;
			rd_val[F_ENABLE] = c1[F_ENABLE];
			rd_val[F_RESISTOR] = c1[F_RESISTOR];
			rd_val[F_DM_SRC] = c1[F_DM_SRC];
			rd_val[F_DP_SINK] = c1[F_DP_SINK];
		end else if (hit_o0) begin
			rd_val[F_ODM_FLAG] = p0_odm_f;
			rd_val[F_ODP_FLAG] = p0_odp_f;
			rd_val[F_DET_EN] = o0[F_DET_EN];
			rd_val[F_OUT_EN] = o0[F_OUT_EN];
			rd_val[SEL_LSB +: SEL_W] = o0[SEL_LSB +: SEL_W];
		end else if (hit_o1) begin
			rd_val[F_ODM_FLAG] = p1_odm_f;
			rd_val[F_ODP_FLAG] = p1_odp_f;
			rd_val[F_DET_EN] = o1[F_DET_EN];
			rd_val[F_OUT_EN] = o1[F_OUT_EN];
			rd_val[SEL_LSB +: SEL_W] = o1[SEL_LSB +: SEL_W];
		end
		// read data only after a read strobe
		if (rd_i) begin
			st_next.rdata_reg = rd_val;
		end else begin
			st_next.rdata_reg = charge_detect_pkg::RESET_VALUE;
		end

		wr_sel = wdata_i[SEL_LSB +: SEL_W];
		if (wr_i) begin
			if (hit_c0) begin
				st_next.ctrl0_reg = charge_detect_pkg::RESET_VALUE;
				st_next.ctrl0_reg[F_ENABLE] = wdata_i[F_ENABLE];
				st_next.ctrl0_reg[F_RESISTOR] = wdata_i[F_RESISTOR];
				st_next.ctrl0_reg[F_DM_SRC] = wdata_i[F_DM_SRC];
				st_next.ctrl0_reg[F_DP_SINK] = wdata_i[F_DP_SINK];
				st_next.ctrl0_reg[F_DP_SRC] = wdata_i[F_DP_SRC];
				st_next.ctrl0_reg[F_DM_SINK] = wdata_i[F_DM_SINK];
				st_next.ctrl0_reg[F_DP_ISRC] = wdata_i[F_DP_ISRC];
				st_next.ctrl0_reg[F_DM_PD] = wdata_i[F_DM_PD];
			end else if (hit_c1) begin
				st_next.ctrl1_reg = charge_detect_pkg::RESET_VALUE;
				st_next.ctrl1_reg[F_ENABLE] = wdata_i[F_ENABLE];
				st_next.ctrl1_reg[F_RESISTOR] = wdata_i[F_RESISTOR];
				st_next.ctrl1_reg[F_DM_SRC] = wdata_i[F_DM_SRC];
				st_next.ctrl1_reg[F_DP_SINK] = wdata_i[F_DP_SINK];
			end else if (hit_o0) begin
				st_next.opt0_reg = charge_detect_pkg::RESET_VALUE;
				st_next.opt0_reg[F_DET_EN] = wdata_i[F_DET_EN];
				st_next.opt0_reg[F_OUT_EN] = wdata_i[F_OUT_EN];
				st_next.opt0_reg[SEL_LSB +: SEL_W] = wr_sel;
			end else if (hit_o1) begin
				st_next.opt1_reg = charge_detect_pkg::RESET_VALUE;
				st_next.opt1_reg[F_DET_EN] = wdata_i[F_DET_EN];
				st_next.opt1_reg[F_OUT_EN] = wdata_i[F_OUT_EN];
				st_next.opt1_reg[SEL_LSB +: SEL_W] = wr_sel;
			end
		end

		// output only for a legal host code
		p1_sel = o1[SEL_LSB +: SEL_W];
		case (p1_sel)
			charge_detect_pkg::SEL_BOTH_200: begin
				p1_host_code = 1'b1;
			end
			charge_detect_pkg::SEL_DP_268: begin
				p1_host_code = 1'b1;
			end
			charge_detect_pkg::SEL_DM_268: begin
				p1_host_code = 1'b1;
			end
			charge_detect_pkg::SEL_BOTH_330: begin
				p1_host_code = 1'b1;
			end
			default: begin
				p1_host_code = 1'b0;
			end
		endcase

		st_next.p0_dp_src_reg = p0_on & c0[F_DP_SRC];
		st_next.p0_dm_src_reg = p0_on & c0[F_DM_SRC];
		// sinks and comparators need the enable
		st_next.p0_dp_sink_reg = p0_on & c0[F_DP_SINK];
		st_next.p0_dm_sink_reg = p0_on & c0[F_DM_SINK];
		st_next.p0_dp_isrc_reg = p0_on & c0[F_DP_ISRC];
		st_next.p0_dm_pd_reg = c0[F_DM_PD];
		st_next.p0_res_reg = c0[F_RESISTOR];
		st_next.p1_res_reg = c1[F_RESISTOR];
		st_next.p1_dm_src_reg = p1_on & c1[F_DM_SRC];
		st_next.p1_dp_sink_reg = p1_on & c1[F_DP_SINK];
		st_next.p0_odet_reg = o0_det;
		st_next.p0_oout_reg = o0[F_OUT_EN];
		st_next.p1_odet_reg = o1_det;
		st_next.p1_oout_reg = o1_out & p1_host_code;
		// port0 select passes all sixteen codes
		st_next.p0_osel_reg = o0[SEL_LSB +: SEL_W];
		st_next.p1_osel_reg = p1_sel;
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rdata_o = st_reg.rdata_reg;

	assign p0_dplus_volt_source_o = st_reg.p0_dp_src_reg;
	assign p0_dminus_volt_source_o = st_reg.p0_dm_src_reg;
	assign p0_dplus_sink_o = st_reg.p0_dp_sink_reg;
	assign p0_dminus_sink_o = st_reg.p0_dm_sink_reg;
	assign p0_dplus_current_source_o = st_reg.p0_dp_isrc_reg;
	assign p0_dminus_pulldown_o = st_reg.p0_dm_pd_reg;
	assign p0_charging_port_resistor_o = st_reg.p0_res_reg;

	assign p1_dminus_volt_source_o = st_reg.p1_dm_src_reg;
	assign p1_dplus_sink_o = st_reg.p1_dp_sink_reg;
	assign p1_charging_port_resistor_o = st_reg.p1_res_reg;

	assign p0_opt_detector_o = st_reg.p0_odet_reg;
	assign p0_opt_output_o = st_reg.p0_oout_reg;
	assign p0_opt_voltage_select_o = st_reg.p0_osel_reg;
	assign p1_opt_detector_o = st_reg.p1_odet_reg;
	assign p1_opt_output_o = st_reg.p1_oout_reg;
	assign p1_opt_voltage_select_o = st_reg.p1_osel_reg;
endmodule
`default_nettype wire

// *** verif/charge_detect_assertions.sv ***
// Purpose: port-level checks of the charger detection register bank
// Assumes: outputs follow a write two edges later, read data one edge
// Notes: bound from the bench top file
`timescale 1ns/10ps
`default_nettype none
module charge_detect_checker #(
	parameter int SYNC_STAGES = 3
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [19:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [15:0] rdata_o,
	input wire logic p0_dplus_volt_source_o,
	input wire logic p0_dminus_volt_source_o,
	input wire logic p0_dplus_sink_o,
	input wire logic p0_dminus_sink_o,
	input wire logic p0_dplus_current_source_o,
	input wire logic p0_dminus_pulldown_o,
	input wire logic p0_charging_port_resistor_o,
	input wire logic p1_dminus_volt_source_o,
	input wire logic p1_dplus_sink_o,
	input wire logic p1_charging_port_resistor_o,
	input wire logic p0_opt_detector_o,
	input wire logic p0_opt_output_o,
	input wire logic [3:0] p0_opt_voltage_select_o,
	input wire logic p1_opt_detector_o,
	input wire logic p1_opt_output_o,
	input wire logic [3:0] p1_opt_voltage_select_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	a_src_gated: assert property (wr_i && addr_i == 20'hF04B0 |-> ##2
		p0_dplus_volt_source_o == ($past(wdata_i[3], 2) && $past(wdata_i[7], 2)))
		else $error("p0 dplus source not gated by enable");
	a_dm_src_gated: assert property (wr_i && addr_i == 20'hF04B0 |-> ##2
		p0_dminus_volt_source_o == ($past(wdata_i[5], 2) && $past(wdata_i[7], 2)))
		else $error("p0 dminus source wrong");
	a_sink_gated: assert property (wr_i && addr_i == 20'hF04B0 |-> ##2
		p0_dminus_sink_o == ($past(wdata_i[2], 2) && $past(wdata_i[7], 2)))
		else $error("p0 dminus sink wrong");
	a_dp_sink_gated: assert property (wr_i && addr_i == 20'hF04B0 |-> ##2
		p0_dplus_sink_o == ($past(wdata_i[4], 2) && $past(wdata_i[7], 2)))
		else $error("p0 dplus sink wrong");
	a_isrc_gated: assert property (wr_i && addr_i == 20'hF04B0 |-> ##2
		p0_dplus_current_source_o == ($past(wdata_i[1], 2) && $past(wdata_i[7], 2)))
		else $error("p0 current source wrong");
	a_pulldown_dm: assert property (wr_i && addr_i == 20'hF04B0 |-> ##2
		p0_dminus_pulldown_o == $past(wdata_i[0], 2)) else $error("pulldown wrong");
	a_resistor_p0: assert property (wr_i && addr_i == 20'hF04B0 |-> ##2
		p0_charging_port_resistor_o == $past(wdata_i[6], 2))
		else $error("p0 resistor wrong");
	a_resistor_p1: assert property (wr_i && addr_i == 20'hF04B4 |-> ##2
		p1_charging_port_resistor_o == $past(wdata_i[6], 2))
		else $error("p1 resistor wrong");
	a_p1_gated: assert property (wr_i && addr_i == 20'hF04B4 |-> ##2
		p1_dplus_sink_o == ($past(wdata_i[4], 2) && $past(wdata_i[7], 2)))
		else $error("p1 dplus sink wrong");
	a_p1_src_gated: assert property (wr_i && addr_i == 20'hF04B4 |-> ##2
		p1_dminus_volt_source_o == ($past(wdata_i[5], 2) && $past(wdata_i[7], 2)))
		else $error("p1 dminus source wrong");
	a_opt_enable: assert property (wr_i && addr_i == 20'hF04B8 |-> ##2
		p0_opt_detector_o == $past(wdata_i[6], 2)) else $error("p0 detector wrong");
	a_opt_output: assert property (wr_i && addr_i == 20'hF04B8 |-> ##2
		p0_opt_output_o == $past(wdata_i[5], 2)) else $error("p0 output wrong");
	a_p0_select: assert property (wr_i && addr_i == 20'hF04B8 |-> ##2
		p0_opt_voltage_select_o == $past(wdata_i[3:0], 2))
		else $error("p0 select wrong");
	a_p1_detector: assert property (wr_i && addr_i == 20'hF04BC |-> ##2
		p1_opt_detector_o == $past(wdata_i[6], 2)) else $error("p1 detector wrong");
	a_p1_select: assert property (wr_i && addr_i == 20'hF04BC |-> ##2
		p1_opt_voltage_select_o == $past(wdata_i[3:0], 2))
		else $error("p1 select wrong");
	a_p1_out_code: assert property (wr_i && addr_i == 20'hF04BC |-> ##2
		p1_opt_output_o == ($past(wdata_i[5], 2)
		&& $past(wdata_i[3:0], 2) inside {4'h8, 4'h9, 4'hA, 4'hC}))
		else $error("p1 output enable wrong");
	a_host_codes: assert property (p1_opt_output_o |->
		p1_opt_voltage_select_o inside {4'h8, 4'h9, 4'hA, 4'hC})
		else $error("p1 output on with illegal code");
	a_unused_zero: assert property (rd_i |=> rdata_o[15:10] == 6'h00)
		else $error("unassigned bits not zero");
	a_flag_valid: assert property (rd_i && addr_i == 20'hF04B0 |=>
		(!rdata_o[9] || rdata_o[4] && rdata_o[7]) && (!rdata_o[8] || rdata_o[2]
		&& rdata_o[7])) else $error("p0 flag set while invalid");
	a_opt_valid: assert property (rd_i && addr_i == 20'hF04B8 |=>
		!rdata_o[9] && !rdata_o[8] || rdata_o[6]) else $error("option flag invalid");
	a_reset_clear: assert property ($past(sys_rst_i) |-> !p1_opt_output_o
		&& !p0_dplus_volt_source_o && !p0_dminus_pulldown_o)
		else $error("outputs not cleared by reset");
endmodule
`default_nettype wire

// *** verif/usb_charger_detect_ctrl_bench.sv ***
// Purpose: self-checking bench for the charger detection registers
// Assumes: read data compared in the cycle after the read strobe
// Notes: random data from an xorshift generator
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((e) !== (s)) begin fails++; \
	$display("mismatch %s exp %h got %h", n, e, s); end end
module usb_charger_detect_ctrl_bench;
	localparam logic [19:0] AD[4] = '{20'hF04B0, 20'hF04B4, 20'hF04B8, 20'hF04BC};
	localparam logic [15:0] MK[4] = '{16'h00FF, 16'h00F0, 16'h006F, 16'h006F};
	localparam logic [1:0] FA[9] = '{0, 0, 0, 1, 1, 2, 2, 3, 3};
	localparam logic [15:0] FW[9] = '{16'h0094, 16'h0014, 16'h0090, 16'h0090,
		16'h0080, 16'h0040, 16'h0020, 16'h0068, 16'h0048};
	localparam logic [15:0] FE[9] = '{16'h0394, 16'h0014, 16'h0290, 16'h0290,
		16'h0080, 16'h0340, 16'h0020, 16'h0368, 16'h0048};
	localparam logic [3:0] HC[5] = '{4'h8, 4'h9, 4'hA, 4'hC, 4'hB};
	logic clk_i = 0, sys_rst_i = 1, wr_i = 0, rd_i = 0, rd_seen = 0;
	logic [19:0] addr_i = '0;
	logic [15:0] wdata_i = '0, rdata_o, e, d;
	logic [6:0] lvl = '0, cmp;
	logic p0_dplus_cmp_i, p0_dminus_cmp_i, p1_dplus_cmp_i, p0_opt_dplus_cmp_i;
	logic p0_opt_dminus_cmp_i, p1_opt_dplus_cmp_i, p1_opt_dminus_cmp_i;
	logic p0_dplus_volt_source_o, p0_dminus_volt_source_o, p0_dplus_sink_o;
	logic p0_dminus_sink_o, p0_dplus_current_source_o, p0_dminus_pulldown_o;
	logic p0_charging_port_resistor_o, p1_dminus_volt_source_o, p1_dplus_sink_o;
	logic p1_charging_port_resistor_o, p0_opt_detector_o, p0_opt_output_o;
	logic p1_opt_detector_o, p1_opt_output_o;
	logic [3:0] p0_opt_voltage_select_o, p1_opt_voltage_select_o;
	logic [15:0] q[$];
	logic [31:0] seed = 32'd57952;
	int fails = 0, comparisons = 0, cycles = 0;
	always #5 clk_i = ~clk_i;
	assign {p0_dplus_cmp_i, p0_dminus_cmp_i, p1_dplus_cmp_i, p0_opt_dplus_cmp_i,
		p0_opt_dminus_cmp_i, p1_opt_dplus_cmp_i, p1_opt_dminus_cmp_i} = cmp;
	usb_charger_detect_ctrl #(.SYNC_STAGES(3)) u_dut (.*);
	usb_line_model u_line (.level_i(lvl), .cmp_o(cmp));
	function automatic logic [15:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction
	task automatic wr(input logic [19:0] a, input logic [15:0] x);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= x;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [19:0] a, input logic [15:0] x);
		q.push_back(x);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
	endtask
	task automatic report_and_stop();
		$display("fails=%0d comparisons=%0d", fails, comparisons);
		if (fails == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge clk_i) begin
		rd_seen <= rd_i;
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			fails++;
			report_and_stop();
		end
	end
	always @(negedge clk_i) if (rd_seen) begin
		e = q.pop_front();
		`CHK("rdata", e, rdata_o)
	end
	initial begin
		repeat (3) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			rd(AD[i], 16'h0000);
			wr(AD[i], 16'hFFFF);
			rd(AD[i], MK[i]);
		end
		rd(20'hF04C0, 16'h0000);
		for (int i = 0; i < 12; i++) begin
			d = rnd();
			wr(AD[d[15:14]], d);
			rd(AD[d[15:14]], d & MK[d[15:14]]);
		end
		lvl <= 7'h7F;
		// sink and detector enables written before flags are read
		for (int i = 0; i < 9; i++) begin
			wr(AD[FA[i]], FW[i]);
			repeat (8) @(posedge clk_i);
			rd(AD[FA[i]], FE[i]);
		end
		lvl <= 7'h00;
		repeat (10) @(posedge clk_i);
		rd(AD[0], 16'h0090);
		for (int i = 0; i < 5; i++) begin
			wr(AD[3], {12'h002, HC[i]});
			@(posedge clk_i);
			@(negedge clk_i);
			`CHK("p1_opt_output", i < 4, p1_opt_output_o)
		end
		for (int i = 0; i < 16; i++) begin
			wr(AD[2], 16'(i));
			@(posedge clk_i);
			@(negedge clk_i);
			`CHK("p0_select", 4'(i), p0_opt_voltage_select_o)
		end
		report_and_stop();
	end
endmodule
bind usb_charger_detect_ctrl charge_detect_checker #(.SYNC_STAGES(SYNC_STAGES))
	u_chk (.*);
`default_nettype wire

// *** verif/usb_line_model.sv ***
// Purpose: connected device seen through the line comparators
// Assumes: comparator levels settle a few ns after the device acts
// Notes: level bits p0 dp, p0 dm, p1 dp, opt p0 dp/dm, opt p1 dp/dm
`timescale 1ns/10ps
`default_nettype none
module usb_line_model (
	input wire logic [6:0] level_i,
	output logic [6:0] cmp_o
);
	// device applies source, async to clock
	assign #3 cmp_o = level_i;
endmodule
`default_nettype wire
